// ### include/link_cmd_pkg.sv
package link_cmd_pkg;
	localparam int node_count = 62;
	localparam int text_len = 20;
	localparam int event_count = 8;
	localparam logic [7:0] node_min = 8'h01;
	localparam logic [7:0] node_max = 8'h3e;
	localparam logic [7:0] ascii_space = 8'h20;
	localparam logic [7:0] byte_off = 8'h00;
	localparam logic [7:0] byte_on = 8'h01;
	localparam logic [7:0] count_max = 8'hff;
	localparam logic [7:0] count_reset = 8'h00;
	localparam int cycle_unit_us = 100;
	localparam int clk_mhz = 250;
	localparam int cycle_unit_clks = cycle_unit_us * clk_mhz;
	localparam logic [2:0] ram_4k = 3'h2;
	localparam logic [2:0] ram_8k = 3'h3;
	localparam logic [2:0] ram_16k = 3'h4;
	localparam int ram_pos = 0;
	localparam int cable_pos = 7;
	localparam int member_bytes = 8;
	localparam int nibble_bytes = 31;
	localparam int mismatch_bit = 0;
	localparam int status_bytes = 5;
	// Response byte offsets per command
	localparam logic [6:0] cd_model = 7'h00;
	localparam logic [6:0] cd_version = 7'h14;
	localparam logic [6:0] cd_ram = 7'h28;
	localparam logic [6:0] cd_node = 7'h29;
	localparam logic [6:0] cd_len = 7'h2a;
	localparam logic [6:0] cs_link = 7'h00;
	localparam logic [6:0] cs_status = 7'h01;
	localparam logic [6:0] cs_events = 7'h06;
	localparam logic [6:0] cs_members = 7'h0e;
	localparam logic [6:0] cs_len = 7'h16;
	localparam logic [6:0] ns_nibbles = 7'h00;
	localparam logic [6:0] ns_cycle = 7'h1f;
	localparam logic [6:0] ns_poll = 7'h21;
	localparam logic [6:0] ns_cyc_op = 7'h22;
	localparam logic [6:0] ns_cyc_tx = 7'h23;
	localparam logic [6:0] ns_errmap = 7'h24;
	localparam logic [6:0] ns_errlog = 7'h2c;
	localparam logic [6:0] ns_len = 7'h6a;
	typedef enum logic [2:0] {
		cmd_link_start,
		cmd_link_halt,
		cmd_unit_reset,
		cmd_ctrl_data,
		cmd_ctrl_status,
		cmd_net_status
	} cmd_t;
	typedef enum logic [1:0] {
		done_ok,
		done_not_allocated,
		done_not_running,
		done_bad_command
	} done_t;
endpackage

// ### hw/sat_counter.sv
module sat_counter
	import link_cmd_pkg::*;
#(
	parameter int width = 8
)
(
	input wire logic clk,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic bump,
	output logic [width-1:0] count
);
	always_ff @(posedge clk)
	begin
		if (clear)
			count <= '0;
		else if (clk_en && bump && count != '1)
			count <= count + 1'b1;
	end
endmodule // sat_counter

// ### hw/cycle_timer.sv
module cycle_timer
	import link_cmd_pkg::*;
#(
	parameter int unit_clks = cycle_unit_clks
)
(
	input wire logic clk,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic cycle_mark,
	output logic [15:0] cycle_units
);
	logic [15:0] tick_q;
	logic [15:0] units_q;
	always_ff @(posedge clk)
	begin
		if (clear)
		begin
			tick_q <= '0;
			units_q <= '0;
			cycle_units <= '0;
		end
		else if (clk_en)
		begin
			if (cycle_mark)
			begin
				// The mark edge closes the running unit only if it is on its last clock; a partial unit is not counted
				if (tick_q == 16'(unit_clks - 1) && units_q != '1)
					cycle_units <= units_q + 1'b1;
				else
					cycle_units <= units_q;
				units_q <= '0;
				tick_q <= '0;
			end
			else if (tick_q == 16'(unit_clks - 1))
			begin
				tick_q <= '0;
				if (units_q != '1)
					units_q <= units_q + 1'b1;
			end
			else
				tick_q <= tick_q + 1'b1;
		end
	end
endmodule // cycle_timer

// ### hw/link_unit_responder.sv
// Operation
// - Link start succeeds only when link words are allocated.
// - Link halt succeeds only while link runs; otherwise error.
// - Unit reset resets the unit and sends no response.
// - Model and version are 20-char ASCII fields padded with spaces.
// - RAM size code in bits 2..0: 010 4K, 011 8K, 100 16K.
// - Own node number byte, valid 01 to 3E.
// - Data link state byte: 00 halted, 01 active.
// - Parameter mismatch sets status flag and resets network parameters.
// - Event counters are bytes saturating at 255.
// - Eight event counters returned in fixed order.
// - Member bitmap: node k at byte (k-1)/8 bit (k-1)%8, top bits zero.
// - Node nibbles packed two per byte in 31 bytes, odd node low.
// - Nibble bit 1 gives absence reason when bit 0 clear.
// - Cycle time reported as 16-bit count of 100 us units.
// - Report current polling unit node number.
// - Cyclic operation byte: 00 stopped, 01 active.
// - Cyclic transmission byte: 00 none, 01 transmitting.
// - Error bitmap: node k at byte k/8 bit k%8, edges zero.
// - 62 per-node cyclic error counters saturating at 255.
module link_unit_responder
	import link_cmd_pkg::*;
#(
	parameter logic [7:0] model_text [text_len] = '{default: ascii_space},
	parameter logic [7:0] version_text [text_len] = '{default: ascii_space},
	parameter logic [2:0] ram_code = ram_8k,
	parameter int unit_clks = link_cmd_pkg::cycle_unit_clks
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic cmd_valid,
	input wire link_cmd_pkg::cmd_t cmd_code,
	output logic cmd_ready,
	output logic done_valid,
	output link_cmd_pkg::done_t done_code,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_last,
	input wire logic rsp_ready,
	output logic unit_reset_pulse,
	output logic params_reload,
	output logic link_active,
	input wire logic words_allocated,
	input wire logic cable_optical,
	input wire logic [7:0] own_node,
	input wire logic param_mismatch,
	input wire logic [status_bytes*8-1:0] other_status,
	input wire logic [event_count-1:0] event_hit,
	input wire logic [node_count-1:0] node_member,
	input wire logic [node_count-1:0] node_absent_reason,
	input wire logic [node_count-1:0] node_status_hi,
	input wire logic [node_count-1:0] node_cyc_err,
	input wire logic cycle_mark,
	input wire logic [7:0] polling_node,
	input wire logic cyclic_running,
	input wire logic cyclic_sending
);
	typedef enum logic [1:0] {st_idle, st_stream} state_t;
	state_t state_q;
	cmd_t cmd_q;
	logic [6:0] idx_q;
	logic [6:0] len;
	logic mismatch_q;
	logic clear_counts;
	logic [7:0] event_cnt [event_count];
	logic [7:0] err_cnt [node_count];
	logic [15:0] cycle_units;
	logic [7:0] rsp_d;
	logic [7:0] member_map [member_bytes];
	logic [7:0] errmap [member_bytes];
	logic [7:0] nibble [nibble_bytes];
	logic [63:0] member_flat;
	logic [63:0] err_flat;
	logic accept;

	// Every command is taken on one edge; nothing is queued behind a busy stream
	assign accept = clk_en && cmd_valid && cmd_ready;
	assign cmd_ready = (state_q == st_idle) && !unit_reset_pulse;
	// Unit reset clears only while enabled, so a frozen block keeps every bit
	assign clear_counts = sys_rst || (clk_en && unit_reset_pulse);

	// Reset is carried out on the cycle after the command; nothing streams back
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			unit_reset_pulse <= 1'b0;
		else if (clk_en)
			unit_reset_pulse <= accept && cmd_code == cmd_unit_reset;
	end

	// Halt of an idle link changes nothing; it is only answered with an error
	always_ff @(posedge clk)
	begin
		if (sys_rst || (clk_en && unit_reset_pulse))
			link_active <= 1'b0;
		else if (accept && cmd_code == cmd_link_start && words_allocated)
			link_active <= 1'b1;
		else if (accept && cmd_code == cmd_link_halt && link_active)
			link_active <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			done_valid <= 1'b0;
			done_code <= done_ok;
		end
		else if (clk_en)
		begin
			// Completion stands one cycle; the code holds for a late reader
			done_valid <= accept && (cmd_code == cmd_link_start || cmd_code == cmd_link_halt);
			if (accept && cmd_code == cmd_link_start)
				done_code <= words_allocated ? done_ok : done_not_allocated;
			else if (accept && cmd_code == cmd_link_halt)
				done_code <= link_active ? done_ok : done_not_running;
		end
	end

	// Mismatch flag stays until the unit is reset; a mismatch in the reset cycle wins
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			mismatch_q <= 1'b0;
			params_reload <= 1'b0;
		end
		else if (clk_en)
		begin
			params_reload <= param_mismatch && (!mismatch_q || unit_reset_pulse);
			if (param_mismatch)
				mismatch_q <= 1'b1;
			else if (unit_reset_pulse)
				mismatch_q <= 1'b0;
		end
	end

	genvar gi;
	generate
		// Counters saturate rather than wrap, so a storm of events reads as 255
		for (gi = 0; gi < event_count; gi++)
		begin : g_event
			sat_counter #(.width(8)) u_cnt (
				.clk(clk),
				.clk_en(clk_en),
				.clear(clear_counts),
				.bump(event_hit[gi]),
				.count(event_cnt[gi])
			);
		end
		for (gi = 0; gi < node_count; gi++)
		begin : g_node
			sat_counter #(.width(8)) u_cnt (
				.clk(clk),
				.clk_en(clk_en),
				.clear(clear_counts),
				.bump(node_cyc_err[gi]),
				.count(err_cnt[gi])
			);
		end
		for (gi = 0; gi < nibble_bytes; gi++)
		begin : g_nib
			// Absence reason only meaningful when the member bit is clear
			assign nibble[gi] = {node_status_hi[2*gi+1], 1'b0,
				node_absent_reason[2*gi+1] & ~node_member[2*gi+1], node_member[2*gi+1],
				node_status_hi[2*gi], 1'b0,
				node_absent_reason[2*gi] & ~node_member[2*gi], node_member[2*gi]};
		end
		for (gi = 0; gi < member_bytes; gi++)
		begin : g_map
			assign member_map[gi] = member_flat[8*gi +: 8];
			assign errmap[gi] = err_flat[8*gi +: 8];
		end
	endgenerate

	assign member_flat = {2'b00, node_member};
	// Node 0 does not exist, so the first bit of the error map is tied low
	assign err_flat = {1'b0, node_cyc_err, 1'b0};

	cycle_timer #(.unit_clks(unit_clks)) u_cycle (
		.clk(clk),
		.clk_en(clk_en),
		.clear(clear_counts),
		.cycle_mark(cycle_mark),
		.cycle_units(cycle_units)
	);

	// Lengths are fixed per command; an unknown code is never streamed, and the default length is one byte
	always_comb
	begin
		unique case (cmd_q)
			cmd_ctrl_data: len = cd_len;
			cmd_ctrl_status: len = cs_len;
			cmd_net_status: len = ns_len;
			default: len = 7'h01;
		endcase
	end

	// Byte chosen by its position within the response being streamed
	always_comb
	begin
		rsp_d = 8'h00;
		unique case (cmd_q)
			cmd_ctrl_data:
			begin
				if (idx_q < cd_version)
					rsp_d = model_text[5'(idx_q - cd_model)];
				else if (idx_q < cd_ram)
					rsp_d = version_text[5'(idx_q - cd_version)];
				else if (idx_q == cd_ram)
					rsp_d = {cable_optical, 4'h0, ram_code};
				else
					// A node number out of range reads 00 so a bad strap never looks valid
					rsp_d = (own_node >= node_min && own_node <= node_max) ? own_node : 8'h00;
			end
			cmd_ctrl_status:
			begin
				if (idx_q == cs_link)
					rsp_d = link_active ? byte_on : byte_off;
				else if (idx_q < cs_events)
				begin
					rsp_d = other_status[8*(idx_q - cs_status) +: 8];
					if (idx_q == cs_status + 7'h2)
						rsp_d[mismatch_bit] = mismatch_q;
				end
				else if (idx_q < cs_members)
					rsp_d = event_cnt[3'(idx_q - cs_events)];
				else
					rsp_d = member_map[3'(idx_q - cs_members)];
			end
			cmd_net_status:
			begin
				if (idx_q < ns_cycle)
					rsp_d = nibble[5'(idx_q - ns_nibbles)];
				else if (idx_q == ns_cycle)
					rsp_d = cycle_units[15:8];
				else if (idx_q == ns_cycle + 7'h1)
					rsp_d = cycle_units[7:0];
				else if (idx_q == ns_poll)
					rsp_d = polling_node;
				else if (idx_q == ns_cyc_op)
					rsp_d = cyclic_running ? byte_on : byte_off;
				else if (idx_q == ns_cyc_tx)
					rsp_d = cyclic_sending ? byte_on : byte_off;
				else if (idx_q < ns_errlog)
					rsp_d = errmap[3'(idx_q - ns_errmap)];
				else
					rsp_d = err_cnt[6'(idx_q - ns_errlog)];
			end
			default: rsp_d = 8'h00;
		endcase
	end

	// Data is registered; each byte holds until the consumer takes it
	always_ff @(posedge clk)
	begin
		if (sys_rst || (clk_en && unit_reset_pulse))
		begin
			state_q <= st_idle;
			cmd_q <= cmd_link_start;
			idx_q <= '0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_last <= 1'b0;
		end
		else if (clk_en)
		begin
			unique case (state_q)
				st_idle:
					if (accept && (cmd_code == cmd_ctrl_data || cmd_code == cmd_ctrl_status
						|| cmd_code == cmd_net_status))
					begin
						cmd_q <= cmd_code;
						idx_q <= '0;
						state_q <= st_stream;
					end
				st_stream:
					if (!rsp_valid || rsp_ready)
					begin
						// The last byte drops valid on the edge that takes it
						if (rsp_valid && rsp_last)
						begin
							rsp_valid <= 1'b0;
							rsp_last <= 1'b0;
							state_q <= st_idle;
						end
						else
						begin
							rsp_valid <= 1'b1;
							rsp_data <= rsp_d;
							rsp_last <= idx_q == len - 7'h1;
							idx_q <= idx_q + 7'h1;
						end
					end
				// A stray state code returns to idle rather than hang the port
				default:
					state_q <= st_idle;
			endcase
		end
	end
endmodule // link_unit_responder

// ### sim/link_unit_responder_asserts.sv
module link_unit_responder_asserts
	import link_cmd_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic cmd_valid,
	input wire link_cmd_pkg::cmd_t cmd_code,
	input wire logic cmd_ready,
	input wire logic done_valid,
	input wire link_cmd_pkg::done_t done_code,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_ready,
	input wire logic unit_reset_pulse,
	input wire logic params_reload,
	input wire logic link_active,
	input wire logic words_allocated
);
	logic go;
	assign go = clk_en && cmd_valid && cmd_ready;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_start_refused: assert property (go && cmd_code == cmd_link_start && !words_allocated
		|=> done_valid && done_code == done_not_allocated && $stable(link_active))
		else $error("start without words not refused");
	a_start_taken: assert property (go && cmd_code == cmd_link_start && words_allocated
		|=> done_valid && done_code == done_ok && link_active)
		else $error("start not done");
	a_halt_idle: assert property (go && cmd_code == cmd_link_halt && !link_active
		|=> done_valid && done_code == done_not_running)
		else $error("idle halt not refused");
	a_halt_running: assert property (go && cmd_code == cmd_link_halt && link_active
		|=> done_valid && done_code == done_ok && !link_active)
		else $error("halt not done");
	a_reset_silent: assert property (go && cmd_code == cmd_unit_reset
		|=> unit_reset_pulse && !done_valid && !rsp_valid ##1 !rsp_valid && !link_active)
		else $error("unit reset answered");
	a_link_byte: assert property (go && cmd_code == cmd_ctrl_status
		|=> ##1 rsp_valid && rsp_data == {7'h00, link_active})
		else $error("bad link state byte");
	a_busy_refuses: assert property (rsp_valid |-> !cmd_ready)
		else $error("command open while streaming");
	a_byte_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
		else $error("byte not held");
	a_reload_once: assert property (params_reload && clk_en && !unit_reset_pulse
		|=> !params_reload)
		else $error("parameter reload longer than one pulse");
	a_freeze_holds: assert property (!clk_en |=> $stable(link_active) && $stable(done_valid)
		&& $stable(rsp_valid) && $stable(rsp_data) && $stable(unit_reset_pulse))
		else $error("state moved while clock enable low");
endmodule // link_unit_responder_asserts
bind link_unit_responder link_unit_responder_asserts link_unit_responder_asserts_inst (
	.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cmd_valid(cmd_valid),
	.cmd_code(cmd_code), .cmd_ready(cmd_ready), .done_valid(done_valid),
	.done_code(done_code), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
	.rsp_ready(rsp_ready), .unit_reset_pulse(unit_reset_pulse), .params_reload(params_reload),
	.link_active(link_active), .words_allocated(words_allocated)
);

// ### sim/cmd_requester.sv
module cmd_requester
	import link_cmd_pkg::*;
(
	input wire logic clk,
	input wire logic cmd_ready,
	input wire logic done_valid,
	input wire link_cmd_pkg::done_t done_code,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_last,
	output logic cmd_valid,
	output link_cmd_pkg::cmd_t cmd_code,
	output logic rsp_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got [$];
	done_t seen;
	initial
	begin
		cmd_valid = 1'b0;
		cmd_code = cmd_link_halt;
		rsp_ready = 1'b0;
	end
	// Enter just after a rising edge; leaves just after one
	task automatic issue(input cmd_t code, input bit slow);
		int n;
		got.delete();
		seen = done_bad_command;
		cmd_valid = 1'b1;
		cmd_code = code;
		n = 0;
		// Ready is combinational; look at it off the edge, where it has settled
		while (!cmd_ready && n < 50)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		// Idle code lines move so a stale code never looks like a live one
		cmd_code = cmd_t'(~code);
		if (code == cmd_unit_reset)
			return;
		if (code == cmd_link_start || code == cmd_link_halt)
		begin
			for (n = 0; n < 3 && !done_valid; n++)
				@(posedge clk) #1;
			if (done_valid)
				seen = done_code;
			// Let an edge pass so a following call never lowers and raises valid at once
			@(posedge clk);
			#1;
			return;
		end
		rsp_ready = !slow;
		for (n = 0; n < 400; n++)
		begin
			@(posedge clk);
			if (rsp_valid && rsp_ready)
				got.push_back(rsp_data);
			if (rsp_valid && rsp_ready && rsp_last)
				break;
			#1 rsp_ready = slow ? !rsp_ready : 1'b1;
		end
		#1 rsp_ready = 1'b0;
	endtask
endmodule // cmd_requester

// ### sim/test_link_unit_command_responder.sv
module test_link_unit_command_responder;
	timeunit 1ns;
	timeprecision 100ps;
	import link_cmd_pkg::*;
	typedef struct {
		cmd_t code;
		logic alloc;
		done_t done;
		logic link;
	} row_t;
	row_t rows [5] = '{
		'{cmd_link_halt, 1'b1, done_not_running, 1'b0},
		'{cmd_link_start, 1'b0, done_not_allocated, 1'b0},
		'{cmd_link_start, 1'b1, done_ok, 1'b1},
		'{cmd_link_halt, 1'b0, done_ok, 1'b0},
		'{cmd_link_start, 1'b1, done_ok, 1'b1}
	};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid, cmd_ready, done_valid, rsp_valid, rsp_last, rsp_ready;
	logic unit_reset_pulse, params_reload, link_active;
	logic words_allocated = 1'b0;
	logic clk_en = 1'b1;
	logic cable_optical = 1'b1;
	logic cyclic_running = 1'b1;
	logic cyclic_sending = 1'b0;
	logic [7:0] own_node = 8'h3e;
	logic [7:0] polling_node = 8'h05;
	logic param_mismatch = 1'b0;
	logic cycle_mark = 1'b0;
	logic [7:0] rsp_data;
	logic [7:0] event_hit = 8'h00;
	logic [61:0] node_cyc_err = 62'h0;
	cmd_t cmd_code;
	done_t done_code;
	logic [7:0] exp [$];
	int fails = 0;
	int checked = 0;
	int ticks = 0;
	int marks = 0;
	always #2 clk = ~clk;
	link_unit_responder #(
		.model_text('{0: 8'h41, 1: 8'h42, default: ascii_space}),
		.version_text('{0: 8'h56, default: ascii_space}),
		.ram_code(ram_16k),
		.unit_clks(4)
	) link_unit_responder_inst (
		.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_ready(cmd_ready), .done_valid(done_valid),
		.done_code(done_code), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_last(rsp_last), .rsp_ready(rsp_ready), .unit_reset_pulse(unit_reset_pulse),
		.params_reload(params_reload), .link_active(link_active),
		.words_allocated(words_allocated), .cable_optical(cable_optical), .own_node(own_node),
		.param_mismatch(param_mismatch), .other_status(40'h11_22_32_44_55),
		.event_hit(event_hit), .node_member(62'h2000_0000_0000_0001),
		.node_absent_reason(62'h3), .node_status_hi(62'h4), .node_cyc_err(node_cyc_err),
		.cycle_mark(cycle_mark), .polling_node(polling_node), .cyclic_running(cyclic_running),
		.cyclic_sending(cyclic_sending)
	);
	cmd_requester cmd_requester_inst (
		.clk(clk), .cmd_ready(cmd_ready), .done_valid(done_valid), .done_code(done_code),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .rsp_ready(rsp_ready)
	);
	task automatic report_and_stop();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic read_expect(input string what, input cmd_t code, input bit slow);
		cmd_requester_inst.issue(code, slow);
		chk({what, " length"}, 8'(cmd_requester_inst.got.size()), 8'(exp.size()));
		foreach (exp[i])
			chk($sformatf("%s byte %0d", what, i), cmd_requester_inst.got[i], exp[i]);
		$display("test %s done", what);
	endtask
	task automatic status_exp(input logic [7:0] lnk, st3, e0, e7);
		exp = '{lnk, 8'h55, 8'h44, st3, 8'h22, 8'h11, e0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, e7, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
	endtask
	task automatic data_exp(input logic [7:0] ram, node);
		exp.delete();
		for (int i = 0; i < 40; i++)
			exp.push_back(i < 2 ? 8'h41 + 8'(i) : i == 20 ? 8'h56 : 8'h20);
		exp = {exp, ram, node};
	endtask
	task automatic net_exp(input logic [7:0] poll, op, tx, m0, m7, c1, c62);
		exp.delete();
		for (int i = 0; i < 31; i++)
			exp.push_back(i == 0 ? 8'h21 : i == 1 ? 8'h08 : i == 30 ? 8'h10 : 8'h00);
		exp = {exp, 8'h00, 8'h0a, poll, op, tx, m0};
		exp = {exp, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, m7, c1};
		for (int i = 0; i < 60; i++)
			exp.push_back(8'h00);
		exp.push_back(c62);
	endtask
	// One mark every 40 clocks gives ten 4-clock units of cycle time
	always @(posedge clk)
	begin
		#1;
		ticks++;
		marks = (marks == 39) ? 0 : marks + 1;
		cycle_mark = (marks == 0);
		if (ticks == 5000)
		begin
			fails++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		#1 sys_rst = 1'b0;
		chk("link after reset", {7'h00, link_active}, 8'h00);
		foreach (rows[i])
		begin
			words_allocated = rows[i].alloc;
			cmd_requester_inst.issue(rows[i].code, 1'b0);
			chk("done code", {6'h00, cmd_requester_inst.seen}, {6'h00, rows[i].done});
			chk("link state", {7'h00, link_active}, {7'h00, rows[i].link});
		end
		$display("test start halt done");
		event_hit = 8'h01;
		repeat (300) @(posedge clk);
		#1 event_hit = 8'h80;
		param_mismatch = 1'b1;
		node_cyc_err = 62'h1;
		@(posedge clk);
		#1 event_hit = 8'h00;
		param_mismatch = 1'b0;
		node_cyc_err = 62'h0;
		data_exp(8'h84, 8'h3e);
		read_expect("controller data", cmd_ctrl_data, 1'b0);
		status_exp(8'h01, 8'h33, 8'hff, 8'h01);
		read_expect("controller status", cmd_ctrl_status, 1'b0);
		net_exp(8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00);
		read_expect("network status", cmd_net_status, 1'b1);
		cmd_requester_inst.issue(cmd_unit_reset, 1'b0);
		repeat (3) @(posedge clk);
		#1 status_exp(8'h00, 8'h32, 8'h00, 8'h00);
		read_expect("after unit reset", cmd_ctrl_status, 1'b0);
		// Errors held long enough to saturate nodes 1 and 62, the edges of the map
		own_node = 8'h3f;
		cable_optical = 1'b0;
		polling_node = 8'h3e;
		cyclic_running = 1'b0;
		cyclic_sending = 1'b1;
		node_cyc_err = 62'h2000_0000_0000_0001;
		repeat (300) @(posedge clk);
		#1 data_exp(8'h04, 8'h00);
		read_expect("controller data out of range", cmd_ctrl_data, 1'b0);
		net_exp(8'h3e, 8'h00, 8'h01, 8'h02, 8'h40, 8'hff, 8'hff);
		read_expect("network errors", cmd_net_status, 1'b0);
		node_cyc_err = 62'h0;
		clk_en = 1'b0;
		event_hit = 8'h01;
		repeat (20) @(posedge clk);
		#1 clk_en = 1'b1;
		event_hit = 8'h00;
		status_exp(8'h00, 8'h32, 8'h00, 8'h00);
		read_expect("frozen counters", cmd_ctrl_status, 1'b0);
		report_and_stop();
	end
endmodule // test_link_unit_command_responder
